// ---- design/owdl_bit_sampler.sv ----
// Fractional 16x bit timer with three-sample majority vote
`timescale 1ns/10ps
`include "owdl_consts.svh"

module owdl_bit_sampler
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic restart_i,
	input wire logic line_i,
	input wire logic [`OWDL_PER_W-1:0] period_i,
	output logic tick_o,
	output logic bit_o,
	output logic bit_valid_o,
	output logic bit_end_o
);
	localparam logic [`OWDL_PER_W:0] STEP = (`OWDL_PER_W+1)'(`OWDL_ACC_STEP);
	localparam logic [3:0] VOTE_A = 4'(`OWDL_VOTE_FIRST - 1);
	localparam logic [3:0] VOTE_C = 4'(`OWDL_VOTE_LAST - 1);

	logic [`OWDL_PER_W:0] acc;
	logic [3:0] idx;
	logic [1:0] votes;
	logic hit;

	// Period spans eight bits; adding 128 per clock gives 16 ticks a bit with the remainder carried
	assign hit = (acc + STEP) >= {1'b0, period_i};

	// ----------------------------------------
	// Tick generation
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || restart_i)
		begin
			acc <= '0;
			idx <= 4'h0;
			tick_o <= 1'b0;
		end
		else if (hit)
		begin
			acc <= acc + STEP - {1'b0, period_i};
			idx <= idx + 4'h1;
			tick_o <= 1'b1;
		end
		else
		begin
			acc <= acc + STEP;
			tick_o <= 1'b0;
		end
	end

	// ----------------------------------------
	// Majority vote on samples 7, 8 and 9
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || restart_i)
		begin
			votes <= 2'h0;
			bit_o <= 1'b1;
			bit_valid_o <= 1'b0;
			bit_end_o <= 1'b0;
		end
		else
		begin
			bit_valid_o <= hit && (idx == VOTE_C);
			bit_end_o <= hit && (idx == 4'hF);
			if (hit && (idx == VOTE_A))
				votes[0] <= line_i;
			if (hit && (idx == VOTE_A + 4'h1))
				votes[1] <= line_i;
			if (hit && (idx == VOTE_C))
				bit_o <= (votes[0] & votes[1]) | (votes[0] & line_i) | (votes[1] & line_i);
		end
	end

endmodule

// ---- design/owdl_phy.sv ----
// Physical layer of the single-wire half-duplex debug link
`timescale 1ns/10ps
`include "owdl_consts.svh"

module owdl_phy #(
	parameter int SYNC_TIMEOUT_CYC = `OWDL_SYNC_TIMEOUT_CYC
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sys_rst_i,
	input wire logic slow_osc_tick_i,
	input wire logic [1:0] reset_pin_function_select_i,
	input wire logic hv_pulse_i,
	input wire logic osc_ready_i,
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_o,
	output logic pin_pullup_o,
	output logic pin_debug_o,
	output logic osc_req_o,
	input wire logic gpio_out_i,
	input wire logic gpio_oe_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	input wire logic expect_data_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic link_err_o
);
	localparam int CPB = `OWDL_CLK_HZ / 1;
	localparam logic [`OWDL_PER_W-1:0] T_MIN_16M = `OWDL_PER_W'((CPB / `OWDL_MAXBAUD_16M) * `OWDL_SYNC_BITS);
	localparam logic [`OWDL_PER_W-1:0] T_MIN_8M = `OWDL_PER_W'((CPB / `OWDL_MAXBAUD_8M) * `OWDL_SYNC_BITS);
	localparam logic [`OWDL_PER_W-1:0] T_MIN_4M = `OWDL_PER_W'((CPB / `OWDL_MAXBAUD_4M) * `OWDL_SYNC_BITS);
	localparam logic [`OWDL_PER_W-1:0] T_MAX_16M = `OWDL_PER_W'((CPB / `OWDL_MINBAUD_16M) * `OWDL_SYNC_BITS);
	localparam logic [`OWDL_PER_W-1:0] T_MAX_8M = `OWDL_PER_W'((CPB / `OWDL_MINBAUD_8M) * `OWDL_SYNC_BITS);
	localparam logic [`OWDL_PER_W-1:0] T_MAX_4M = `OWDL_PER_W'((CPB / `OWDL_MINBAUD_4M) * `OWDL_SYNC_BITS);
	localparam logic [`OWDL_PER_W-1:0] T_DEFAULT = `OWDL_PER_W'((CPB / `OWDL_DEF_BAUD) * `OWDL_SYNC_BITS);
	localparam logic [21:0] TIMEOUT_LAST = 22'(SYNC_TIMEOUT_CYC - 1);
	localparam logic [7:0] BREAK_LAST = 8'(`OWDL_BREAK_TICKS - 1);
	localparam logic [9:0] PROT_CYC = 10'(`OWDL_GPIO_PROT_SLOW_CYC);

	owdl_pkg::owdl_state_t state;
	logic pin_q;
	logic hv_q;
	logic hv_mode;
	logic first_sync;
	logic sync_expected;
	logic [1:0] clk_sel;
	logic [`OWDL_PER_W-1:0] period;
	logic [`OWDL_PER_W-1:0] meas_cnt;
	logic [`OWDL_PER_W-1:0] t_min;
	logic [`OWDL_PER_W-1:0] t_max;
	logic [2:0] edge_cnt;
	logic [3:0] bit_idx;
	logic [7:0] rx_sh;
	logic [11:0] tx_sh;
	logic [21:0] to_cnt;
	logic [7:0] low_ticks;
	logic [9:0] prot_cnt;
	logic s_tick;
	logic s_bit;
	logic s_bit_valid;
	logic s_bit_end;
	logic fall;
	logic port_on;
	logic hv_rise;
	logic dis_wr;
	logic listening;
	logic break_det;
	logic tx_take;
	logic samp_restart;
	logic rx_bad;
	logic sync_last_edge;

	assign fall = pin_q & ~pin_i;
	assign hv_rise = hv_pulse_i & ~hv_q;
	assign port_on = hv_mode || (reset_pin_function_select_i == `OWDL_PIN_DEBUG);
	assign dis_wr = reg_wr_i && (reg_addr_i == `OWDL_REG_CTRL_B) && reg_wdata_i[`OWDL_DISABLE_BIT];
	assign listening = state inside {owdl_pkg::ST_IDLE, owdl_pkg::ST_SYNC, owdl_pkg::ST_SYNC_TAIL,
		owdl_pkg::ST_RX, owdl_pkg::ST_ERROR};
	assign break_det = listening && s_tick && !pin_i && (low_ticks == BREAK_LAST);
	assign tx_take = tx_valid_i && tx_ready_o && (state == owdl_pkg::ST_IDLE) && !fall;
	assign sync_last_edge = fall && (state == owdl_pkg::ST_SYNC) && (edge_cnt == 3'h3);
	assign samp_restart = (fall && (state == owdl_pkg::ST_IDLE)) || sync_last_edge || tx_take;

	always_comb
	begin
		unique case (bit_idx)
			4'h0: rx_bad = s_bit;
			4'h9: rx_bad = (^rx_sh) ^ s_bit;
			4'hA, 4'hB: rx_bad = !s_bit;
			default: rx_bad = 1'b0;
		endcase
	end

	always_comb
	begin
		unique case (clk_sel)
			`OWDL_SEL_16M:
			begin
				t_min = T_MIN_16M;
				t_max = T_MAX_16M;
			end
			`OWDL_SEL_8M:
			begin
				t_min = T_MIN_8M;
				t_max = T_MAX_8M;
			end
			default:
			begin
				t_min = T_MIN_4M;
				t_max = T_MAX_4M;
			end
		endcase
	end

	owdl_bit_sampler u_sampler
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.restart_i(samp_restart),
		.line_i(pin_i),
		.period_i(period),
		.tick_o(s_tick),
		.bit_o(s_bit),
		.bit_valid_o(s_bit_valid),
		.bit_end_o(s_bit_end)
	);

	// ----------------------------------------
	// Edge history and high-voltage mode
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pin_q <= 1'b1;
			hv_q <= 1'b0;
			hv_mode <= 1'b0;
		end
		else
		begin
			pin_q <= pin_i;
			hv_q <= hv_pulse_i;
			if (hv_rise)
				hv_mode <= 1'b1;
		end
	end

	// ----------------------------------------
	// Link state machine
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state <= owdl_pkg::ST_OFF;
			osc_req_o <= 1'b0;
			first_sync <= 1'b0;
			sync_expected <= 1'b1;
			clk_sel <= `OWDL_SEL_DEFAULT;
			period <= T_DEFAULT;
		end
		// port reset, back to waiting for enable pulse
		else if (hv_rise || dis_wr || !port_on)
		begin
			state <= (port_on || hv_rise) ? owdl_pkg::ST_ARMED : owdl_pkg::ST_OFF;
			osc_req_o <= 1'b0;
			first_sync <= 1'b0;
			sync_expected <= 1'b1;
			clk_sel <= `OWDL_SEL_DEFAULT;
			period <= T_DEFAULT;
		end
		else if (break_det)
		begin
			state <= owdl_pkg::ST_IDLE;
			first_sync <= 1'b0;
			sync_expected <= 1'b1;
			clk_sel <= `OWDL_SEL_DEFAULT;
		end
		else
		begin
			if (reg_wr_i && (reg_addr_i == `OWDL_REG_CTRL_A))
				clk_sel <= reg_wdata_i[`OWDL_CLKSEL_LSB +: 2];
			unique case (state)
				owdl_pkg::ST_OFF:
					state <= owdl_pkg::ST_ARMED;
				owdl_pkg::ST_ARMED:
					if (fall)
					begin
						state <= owdl_pkg::ST_HOLD;
						osc_req_o <= 1'b1;
					end
				owdl_pkg::ST_HOLD:
					if (osc_ready_i)
					begin
						state <= owdl_pkg::ST_IDLE;
						first_sync <= 1'b1;
						sync_expected <= 1'b1;
					end
				owdl_pkg::ST_IDLE:
					if (first_sync && (to_cnt == TIMEOUT_LAST))
					begin
						state <= owdl_pkg::ST_ARMED;
						osc_req_o <= 1'b0;
						first_sync <= 1'b0;
					end
					else if (fall)
						state <= sync_expected ? owdl_pkg::ST_SYNC : owdl_pkg::ST_RX;
					else if (tx_take)
						state <= owdl_pkg::ST_TX;
				owdl_pkg::ST_SYNC:
					// bad first sync disables, later ones are errors
					if ((meas_cnt > t_max) || (sync_last_edge && (meas_cnt + 1'b1 < t_min)))
					begin
						state <= first_sync ? owdl_pkg::ST_ARMED : owdl_pkg::ST_ERROR;
						osc_req_o <= osc_req_o && !first_sync;
						first_sync <= 1'b0;
					end
					else if (sync_last_edge)
					begin
						period <= meas_cnt + 1'b1;
						state <= owdl_pkg::ST_SYNC_TAIL;
						first_sync <= 1'b0;
						sync_expected <= 1'b0;
					end
				owdl_pkg::ST_SYNC_TAIL:
					// Skip rest of sync frame; leave mid last stop so a back-to-back start is seen
					if (s_bit_valid && (bit_idx == 4'h3))
						state <= owdl_pkg::ST_IDLE;
				owdl_pkg::ST_RX:
					if (s_bit_valid && rx_bad)
						state <= owdl_pkg::ST_ERROR;
					else if (s_bit_valid && (bit_idx == 4'hB))
					begin
						state <= owdl_pkg::ST_IDLE;
						sync_expected <= !expect_data_i;
					end
				owdl_pkg::ST_TX:
					if (s_bit_end && (bit_idx == 4'hB))
					begin
						state <= owdl_pkg::ST_IDLE;
						sync_expected <= !expect_data_i;
					end
				owdl_pkg::ST_ERROR:
					// only a break or a port reset leaves this state
					state <= owdl_pkg::ST_ERROR;
			endcase
		end
	end

	// ----------------------------------------
	// Measurement, timeout and break counters
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || (state != owdl_pkg::ST_SYNC))
		begin
			meas_cnt <= '0;
			edge_cnt <= 3'h0;
		end
		else
		begin
			meas_cnt <= meas_cnt + 1'b1;
			if (fall)
				edge_cnt <= edge_cnt + 3'h1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || (state != owdl_pkg::ST_IDLE) || !first_sync)
			to_cnt <= 22'h0;
		else
			to_cnt <= to_cnt + 22'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || !listening || pin_i)
			low_ticks <= 8'h00;
		else if (s_tick && (low_ticks != BREAK_LAST + 8'h01))
			low_ticks <= low_ticks + 8'h01;
	end

	// ----------------------------------------
	// Frame shifters
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			bit_idx <= 4'h0;
			rx_sh <= 8'h00;
			tx_sh <= 12'hFFF;
			rx_data_o <= 8'h00;
			rx_valid_o <= 1'b0;
		end
		else
		begin
			rx_valid_o <= 1'b0;
			if (samp_restart)
				bit_idx <= 4'h0;
			if (tx_take)
				// start, data LSB first, even parity, two stops
				tx_sh <= {2'b11, ^tx_data_i, tx_data_i, 1'b0};
			else if ((state == owdl_pkg::ST_TX) && s_bit_end)
				tx_sh <= {1'b1, tx_sh[11:1]};
			if (!samp_restart && s_bit_valid && (state == owdl_pkg::ST_RX))
			begin
				bit_idx <= bit_idx + 4'h1;
				if ((bit_idx >= 4'h1) && (bit_idx <= 4'h8))
					rx_sh <= {s_bit, rx_sh[7:1]};
				if ((bit_idx == 4'hB) && !rx_bad)
				begin
					rx_data_o <= rx_sh;
					rx_valid_o <= 1'b1;
				end
			end
			else if (!samp_restart && s_bit_end && (state inside {owdl_pkg::ST_TX, owdl_pkg::ST_SYNC_TAIL}))
				bit_idx <= bit_idx + 4'h1;
		end
	end

	// ----------------------------------------
	// GPIO output protection window
	// ----------------------------------------
	// count slow oscillator cycles
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || sys_rst_i)
			prot_cnt <= 10'h000;
		else if (slow_osc_tick_i && (prot_cnt != PROT_CYC))
			prot_cnt <= prot_cnt + 10'h001;
	end

	// ----------------------------------------
	// Pin and status outputs
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pin_o <= 1'b1;
			pin_oe_o <= 1'b0;
			pin_pullup_o <= 1'b0;
			pin_debug_o <= 1'b0;
			tx_ready_o <= 1'b0;
			link_err_o <= 1'b0;
		end
		else
		begin
			pin_debug_o <= port_on;
			pin_pullup_o <= port_on;
			tx_ready_o <= (state == owdl_pkg::ST_IDLE) && !sync_expected && !tx_take && !fall;
			link_err_o <= (state == owdl_pkg::ST_ERROR);
			// drive in hold or transmit, or from the GPIO inputs when the port is off in GPIO mode
			if (state == owdl_pkg::ST_HOLD)
			begin
				pin_o <= 1'b0;
				pin_oe_o <= 1'b1;
			end
			else if (state == owdl_pkg::ST_TX)
			begin
				pin_o <= tx_sh[0];
				pin_oe_o <= 1'b1;
			end
			else if (!port_on && (reset_pin_function_select_i == `OWDL_PIN_GPIO))
			begin
				pin_o <= gpio_out_i;
				pin_oe_o <= gpio_oe_i && !sys_rst_i && (prot_cnt == PROT_CYC);
			end
			else
			begin
				pin_o <= 1'b1;
				pin_oe_o <= 1'b0;
			end
		end
	end

	// Read data stand one cycle, zero otherwise
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || !reg_rd_i)
			reg_rdata_o <= 8'h00;
		else if (reg_addr_i == `OWDL_REG_CTRL_A)
			reg_rdata_o <= {6'h00, clk_sel};
		else if (reg_addr_i == `OWDL_REG_STATUS)
			reg_rdata_o <= {hv_mode, osc_req_o, state == owdl_pkg::ST_ERROR, first_sync, sync_expected,
				state == owdl_pkg::ST_IDLE, state == owdl_pkg::ST_ARMED, state == owdl_pkg::ST_OFF};
		else
			reg_rdata_o <= 8'h00;
	end

endmodule

// ---- dv/owdl_debugger_model.sv ----
// Behavioural debugger on the far end of the single-wire link
`timescale 1ns/10ps
module owdl_debugger_model #(
	parameter int BIT = 920
)
(
	input wire logic clk_i,
	input wire logic line_i,
	output logic drv_low_o
);
	initial drv_low_o = 1'b0;

	task automatic hold(input logic low, input int n);
		@(posedge clk_i);
		drv_low_o <= low;
		repeat (n - 1) @(posedge clk_i);
	endtask

	task automatic pulse();
		hold(1'b1, 100);
		hold(1'b0, 1);
	endtask

	// start, LSB first, even parity (odd when flip is set), two stops
	task automatic send_frame(input logic [7:0] d, input logic flip);
		logic [11:0] f;
		f = {2'b11, ^d ^ flip, d, 1'b0};
		for (int i = 0; i < 12; i++)
			hold(!f[i], BIT);
	endtask

	// long break, then a stop period high
	task automatic send_break();
		hold(1'b1, 12 * BIT + BIT / 2);
		hold(1'b0, BIT);
	endtask

	// sample each bit centre of a device frame
	task automatic get_frame(output logic [7:0] d, output logic ok);
		logic [11:0] f;
		int n;
		n = 0;
		while (line_i && n < 5000)
		begin
			@(posedge clk_i);
			n++;
		end
		repeat (BIT / 2) @(posedge clk_i);
		for (int i = 0; i < 12; i++)
		begin
			f[i] = line_i;
			repeat (BIT) @(posedge clk_i);
		end
		d = f[8:1];
		ok = !f[0] && !(^f[9:1]) && f[11] && f[10];
	endtask
endmodule

// ---- dv/owdl_phy_monitor.sv ----
// Port checker for the debug link physical layer
`timescale 1ns/10ps
module owdl_phy_monitor #(
	parameter int SYNC_TIMEOUT_CYC = 2000
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sys_rst_i,
	input wire logic hv_pulse_i,
	input wire logic osc_ready_i,
	input wire logic pin_i,
	input wire logic pin_o,
	input wire logic pin_oe_o,
	input wire logic pin_debug_o,
	input wire logic osc_req_o,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic rx_valid_o,
	input wire logic tx_valid_i,
	input wire logic tx_ready_o,
	input wire logic link_err_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_reset_quiet: assert property ($rose(rst_n_i) |-> !pin_oe_o && !osc_req_o && !link_err_o)
		else $error("outputs active after reset");
	a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data without read");
	a_enable_hold: assert property ($fell(pin_i) && pin_debug_o && !osc_req_o && !pin_oe_o
		|-> ##[1:3] (osc_req_o && pin_oe_o && !pin_o))
		else $error("enable edge not held low");
	a_hold_release: assert property ($rose(osc_ready_i) && pin_oe_o |-> ##[1:4] !pin_oe_o)
		else $error("line not released");
	a_rx_no_drive: assert property (rx_valid_o |-> !pin_oe_o)
		else $error("driving while receiving");
	a_err_no_rx: assert property (link_err_o |-> !rx_valid_o)
		else $error("byte delivered in error state");
	a_err_sticky: assert property (link_err_o && pin_debug_o && $past(pin_i) && !$past(reg_wr_i)
		&& !$past(hv_pulse_i) |=> link_err_o)
		else $error("error left without break");
	a_gpio_block: assert property (sys_rst_i && !pin_debug_o |=> !pin_oe_o)
		else $error("gpio driven after system reset");
	a_tx_start: assert property (tx_valid_i && tx_ready_o |-> ##2 (pin_oe_o && !pin_o))
		else $error("no start bit");
	a_tx_busy: assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o [*8])
		else $error("ready during frame");
endmodule

bind owdl_phy owdl_phy_monitor #(.SYNC_TIMEOUT_CYC(SYNC_TIMEOUT_CYC)) u_mon (.clk_i, .rst_n_i, .sys_rst_i,
	.hv_pulse_i, .osc_ready_i, .pin_i, .pin_o, .pin_oe_o, .pin_debug_o, .osc_req_o, .reg_wr_i, .reg_rd_i,
	.reg_rdata_o, .rx_valid_o, .tx_valid_i, .tx_ready_o, .link_err_o);

// ---- dv/tb_one_wire_debug_link_phy.sv ----
// Self-checking bench of the debug link physical layer
`timescale 1ns/10ps
module tb_one_wire_debug_link_phy;
	localparam int SYNC_TO = 2000;
	logic clk_i, rst_n_i, sys_rst_i, slow_osc_tick_i, hv_pulse_i, osc_ready_i, gpio_out_i, gpio_oe_i;
	logic reg_wr_i, reg_rd_i, expect_data_i, tx_valid_i, ok, drv_low;
	logic pin_o, pin_oe_o, pin_pullup_o, pin_debug_o, osc_req_o, rx_valid_o, tx_ready_o, link_err_o;
	logic [1:0] reset_pin_function_select_i, sc;
	logic [3:0] reg_addr_i;
	logic [7:0] reg_wdata_i, tx_data_i, reg_rdata_o, rx_data_o, rd_val, rx_byte, rx_last;
	int err_total = 0, num_checks = 0, rx_cnt = 0, osc_cnt = 0, n;
	wire pin_i = !((pin_oe_o && !pin_o) || drv_low);
	logic [19:0] rows [4] = '{20'h0_01_01, 20'h0_02_02, 20'h0_03_03, 20'hF_AA_00};

	owdl_phy #(.SYNC_TIMEOUT_CYC(SYNC_TO)) DUT (.clk_i, .rst_n_i, .sys_rst_i, .slow_osc_tick_i,
		.reset_pin_function_select_i, .hv_pulse_i, .osc_ready_i, .pin_i, .pin_o, .pin_oe_o, .pin_pullup_o,
		.pin_debug_o, .osc_req_o, .gpio_out_i, .gpio_oe_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .rx_data_o, .rx_valid_o, .expect_data_i, .tx_data_i, .tx_valid_i, .tx_ready_o, .link_err_o);
	owdl_debugger_model #(.BIT(900)) dbg (.clk_i, .line_i(pin_i), .drv_low_o(drv_low));

	// ----------------------------------------
	// Clock, slow tick, oscillator, receive log
	// ----------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = !clk_i;
	end
	always @(posedge clk_i)
	begin
		sc <= sc + 2'h1;
		slow_osc_tick_i <= (sc == 2'h3);
		osc_cnt <= osc_req_o ? osc_cnt + 1 : 0;
		osc_ready_i <= osc_req_o && osc_cnt > 200;
		if (rx_valid_o)
		begin
			rx_cnt <= rx_cnt + 1;
			rx_last <= rx_data_o;
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		if (err_total == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	task automatic wait_osc(input logic lvl);
		for (n = 0; osc_req_o !== lvl && n < 300; n++) @(posedge clk_i);
	endtask
	task automatic wait_oe(input logic lvl);
		for (n = 0; pin_oe_o !== lvl && n < 300; n++) @(posedge clk_i);
	endtask

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial
	begin
		repeat (110000) @(posedge clk_i);
		err_total++;
		end_of_test();
	end
	initial
	begin
		{rst_n_i, sys_rst_i, hv_pulse_i, gpio_out_i, gpio_oe_i, reg_wr_i, reg_rd_i, expect_data_i, tx_valid_i} = '0;
		{sc, slow_osc_tick_i, osc_ready_i, reg_addr_i, reg_wdata_i, tx_data_i} = '0;
		reset_pin_function_select_i = 2'h1;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		reg_read(4'h0, rd_val);
		check(rd_val, 8'h03);
		foreach (rows[i])
		begin
			reg_write(rows[i][19:16], rows[i][15:8]);
			reg_read(rows[i][19:16], rd_val);
			check(rd_val, rows[i][7:0]);
		end
		check(8'({pin_pullup_o, pin_debug_o}), 8'h03);
		dbg.pulse();
		wait_osc(1'b1);
		check(8'({pin_oe_o, pin_o}), 8'h02);
		wait_oe(1'b0);
		check(8'(osc_req_o), 8'h01);
		expect_data_i <= 1'b1;
		dbg.send_frame(8'h55, 1'b0);
		dbg.send_frame(8'hA5, 1'b0);
		check(rx_last, 8'hA5);
		expect_data_i <= 1'b0;
		tx_data_i <= 8'h3C;
		tx_valid_i <= 1'b1;
		n = 0;
		do @(posedge clk_i); while (tx_ready_o !== 1'b1 && ++n < 100);
		tx_valid_i <= 1'b0;
		dbg.get_frame(rx_byte, ok);
		check(rx_byte, 8'h3C);
		check(8'(ok), 8'h01);
		dbg.send_frame(8'h55, 1'b0);
		dbg.send_frame(8'h11, 1'b1);
		check(8'(link_err_o), 8'h01);
		n = rx_cnt;
		dbg.send_frame(8'h22, 1'b0);
		check(8'(rx_cnt - n), 8'h00);
		reg_write(4'h0, 8'h01);
		dbg.send_break();
		check(8'(link_err_o), 8'h00);
		reg_read(4'h0, rd_val);
		check(rd_val, 8'h03);
		reg_write(4'h1, 8'h04);
		wait_osc(1'b0);
		check(8'({osc_req_o, pin_debug_o}), 8'h01);
		dbg.pulse();
		wait_osc(1'b1);
		wait_oe(1'b0);
		repeat (SYNC_TO - 100) @(posedge clk_i);
		check(8'(osc_req_o), 8'h01);
		repeat (200) @(posedge clk_i);
		check(8'(osc_req_o), 8'h00);
		reset_pin_function_select_i <= 2'h0;
		gpio_oe_i <= 1'b1;
		sys_rst_i <= 1'b1;
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (767 * 4 - 20) @(posedge clk_i);
		check(8'({pin_debug_o, pin_oe_o}), 8'h00);
		repeat (60) @(posedge clk_i);
		check(8'(pin_oe_o), 8'h01);
		hv_pulse_i <= 1'b1;
		repeat (20000) @(posedge clk_i);
		hv_pulse_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		check(8'({pin_debug_o, pin_oe_o}), 8'h02);
		reg_write(4'h1, 8'h04);
		repeat (4) @(posedge clk_i);
		check(8'(pin_debug_o), 8'h01);
		end_of_test();
	end
endmodule

// ---- shared/owdl_consts.svh ----
// Constants of the single-wire debug link physical layer
`ifndef OWDL_CONSTS_SVH
`define OWDL_CONSTS_SVH

// ----------------------------------------
// Clock and sampling
// ----------------------------------------
`define OWDL_CLK_HZ 200000000
`define OWDL_SYNC_BITS 8
`define OWDL_SAMPLES_PER_BIT 16
`define OWDL_ACC_STEP (`OWDL_SYNC_BITS * `OWDL_SAMPLES_PER_BIT)
`define OWDL_VOTE_FIRST 7
`define OWDL_VOTE_LAST 9
`define OWDL_FRAME_BITS 12
`define OWDL_BREAK_TICKS (`OWDL_FRAME_BITS * `OWDL_SAMPLES_PER_BIT)
`define OWDL_PER_W 26

// ----------------------------------------
// Clock speed selection and baud windows
// ----------------------------------------
`define OWDL_SEL_16M 2'h1
`define OWDL_SEL_8M 2'h2
`define OWDL_SEL_4M 2'h3
`define OWDL_SEL_DEFAULT `OWDL_SEL_4M
`define OWDL_MAXBAUD_16M 900000
`define OWDL_MAXBAUD_8M 450000
`define OWDL_MAXBAUD_4M 225000
`define OWDL_MINBAUD_16M 300
`define OWDL_MINBAUD_8M 150
`define OWDL_MINBAUD_4M 75
`define OWDL_DEF_BAUD 225000

// ----------------------------------------
// Enable, timeout and pin protection
// ----------------------------------------
`define OWDL_PIN_GPIO 2'h0
`define OWDL_PIN_DEBUG 2'h1
`define OWDL_SYNC_TIMEOUT_US 13500
`define OWDL_SYNC_TIMEOUT_CYC (`OWDL_SYNC_TIMEOUT_US * (`OWDL_CLK_HZ / 1000000))
`define OWDL_GPIO_PROT_SLOW_CYC 768

// ----------------------------------------
// Register port
// ----------------------------------------
`define OWDL_REG_CTRL_A 4'h0
`define OWDL_REG_CTRL_B 4'h1
`define OWDL_REG_STATUS 4'h2
`define OWDL_CLKSEL_LSB 0
`define OWDL_DISABLE_BIT 2

`endif

// ---- shared/owdl_pkg.sv ----
// Types of the single-wire debug link physical layer
package owdl_pkg;

	typedef enum logic [8:0]
	{
		ST_OFF       = 9'h001,
		ST_ARMED     = 9'h002,
		ST_HOLD      = 9'h004,
		ST_IDLE      = 9'h008,
		ST_SYNC      = 9'h010,
		ST_SYNC_TAIL = 9'h020,
		ST_RX        = 9'h040,
		ST_TX        = 9'h080,
		ST_ERROR     = 9'h100
	} owdl_state_t;

endpackage
